// ---- hw/fpeg_core.sv ----
// Core-side driver: AXI4-Lite command registers that drive the gate link.
`default_nettype none

module fpeg_core (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [fpeg_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [fpeg_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    fpeg_link_if.core link
);
    import fpeg_pkg::*;

    typedef struct packed {
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [FLASH_AW-1:0] faddr;
        logic [7:0] result;
        logic [EV_N-1:0] status;
        logic [EV_N-1:0] int_en;
        fpeg_hstate_t st;
        logic sfr_wr;
        logic sfr_rd;
        logic [7:0] sfr_addr;
        logic [7:0] sfr_wdata;
        logic mv_valid;
        logic [7:0] mv_data;
        logic fr_valid;
    } fpeg_core_state_t;

    fpeg_core_state_t s;
    fpeg_core_state_t next_s;
    logic wr_go;
    logic rd_go;
    logic [EV_N-1:0] ev;
    logic [EV_N-1:0] clr;

    // Address and data are taken together, so either arrival order works.
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s.bvalid;
    assign rd_go = s_axi_arvalid && !s.rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rdata = s.rdata;
    assign irq = |(s.status & s.int_en);
    assign link.sfr_wr = s.sfr_wr;
    assign link.sfr_rd = s.sfr_rd;
    assign link.sfr_addr = s.sfr_addr;
    assign link.sfr_wdata = s.sfr_wdata;
    assign link.mv_valid = s.mv_valid;
    assign link.mv_addr = s.faddr;
    assign link.mv_data = s.mv_data;
    assign link.fr_valid = s.fr_valid;
    assign link.fr_addr = s.faddr;

    always_comb begin
        next_s = s;
        ev = '0;
        clr = '0;
        next_s.sfr_wr = 1'b0;
        next_s.sfr_rd = 1'b0;
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end

        unique case (s.st)
            FPEG_H_IDLE: begin
            end
            FPEG_H_SFR_RD: begin
                next_s.st = FPEG_H_SFR_RD2;
            end
            FPEG_H_SFR_RD2: begin
                next_s.result = link.sfr_rdata;
                ev[EV_DONE] = 1'b1;
                next_s.st = FPEG_H_IDLE;
            end
            FPEG_H_MOVE: begin
                if (link.mv_ready) begin
                    next_s.mv_valid = 1'b0;
                    ev[EV_DONE] = 1'b1;
                    next_s.st = FPEG_H_IDLE;
                end
            end
            FPEG_H_FREAD: begin
                if (s.fr_valid && link.fr_ready) begin
                    next_s.fr_valid = 1'b0;
                end
                if (link.fr_done) begin
                    next_s.result = link.fr_data;
                    ev[EV_DONE] = 1'b1;
                    next_s.st = FPEG_H_IDLE;
                end
            end
            default: begin
                next_s.st = FPEG_H_IDLE;
            end
        endcase

        if (wr_go) begin
            next_s.bvalid = 1'b1;
            next_s.bresp = RESP_OKAY;
            unique case (s_axi_awaddr)
                REG_ADDR: begin
                    next_s.faddr = s_axi_wdata[FLASH_AW-1:0];
                end
                REG_INT_EN: begin
                    next_s.int_en = s_axi_wdata[EV_N-1:0];
                end
                REG_INT_CLR: begin
                    clr = s_axi_wdata[EV_N-1:0];
                end
                REG_CMD: begin
                    // One command at a time; later ones are refused.
                    if (s.st != FPEG_H_IDLE) begin
                        ev[EV_REFUSED] = 1'b1;
                    end else begin
                        unique case (s_axi_wdata[17:16])
                            OP_FLASH_READ: begin
                                next_s.fr_valid = 1'b1;
                                next_s.st = FPEG_H_FREAD;
                            end
                            OP_SFR_WRITE: begin
                                next_s.sfr_wr = 1'b1;
                                ev[EV_DONE] = 1'b1;
                            end
                            OP_SFR_READ: begin
                                next_s.sfr_rd = 1'b1;
                                next_s.st = FPEG_H_SFR_RD;
                            end
                            OP_MOVE_WRITE: begin
                                next_s.mv_valid = 1'b1;
                                next_s.st = FPEG_H_MOVE;
                            end
                        endcase
                        next_s.sfr_addr = s_axi_wdata[15:8];
                        next_s.sfr_wdata = s_axi_wdata[7:0];
                        next_s.mv_data = s_axi_wdata[7:0];
                    end
                end
                default: begin
                    next_s.bresp = RESP_SLVERR;
                end
            endcase
        end

        if (rd_go) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = RESP_OKAY;
            next_s.rdata = 32'h0000_0000;
            unique case (s_axi_araddr)
                REG_ADDR: begin
                    next_s.rdata[FLASH_AW-1:0] = s.faddr;
                end
                REG_RESULT: begin
                    next_s.rdata[7:0] = s.result;
                    next_s.rdata[RESULT_BUSY_BIT] = (s.st != FPEG_H_IDLE);
                end
                REG_STATUS: begin
                    next_s.rdata[EV_N-1:0] = s.status;
                end
                REG_INT_EN: begin
                    next_s.rdata[EV_N-1:0] = s.int_en;
                end
                default: begin
                    next_s.rresp = RESP_SLVERR;
                end
            endcase
        end

        // A new event in the clearing cycle survives the clear.
        next_s.status = (s.status & ~clr) | ev;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.st <= FPEG_H_IDLE;
        end else begin
            s <= next_s;
        end
    end

endmodule // fpeg_core

`default_nettype wire

// ---- pkg/fpeg_pkg.sv ----
// Shared constants and types for the flash program/erase gate and its driver.
`default_nettype none

package fpeg_pkg;

    // Special-function register addresses on the device port.
    localparam logic [7:0] SFR_STORE_CTRL = 8'h8f;
    localparam logic [7:0] SFR_READ_TIMING = 8'hb6;
    localparam logic [7:0] SFR_UNLOCK_KEY = 8'hb7;

    // Field positions and reset values.
    localparam int WRITE_EN_BIT = 0;
    localparam int ERASE_EN_BIT = 1;
    localparam int ONE_SHOT_BIT = 7;
    localparam logic [7:0] STORE_CTRL_RESET = 8'h00;
    localparam logic [7:0] READ_TIMING_RESET = 8'h80;

    // Unlock key codes and lock states.
    localparam logic [7:0] KEY_FIRST = 8'ha5;
    localparam logic [7:0] KEY_SECOND = 8'hf1;
    localparam logic [1:0] LOCK_LOCKED = 2'h0;
    localparam logic [1:0] LOCK_FIRST = 2'h1;
    localparam logic [1:0] LOCK_OPEN = 2'h2;
    localparam logic [1:0] LOCK_DEAD = 2'h3;

    // Flash geometry: 8 kB in 512-byte pages.
    localparam int FLASH_AW = 13;
    localparam int PAGE_AW = 9;
    localparam int FLASH_BYTES = 8192;
    localparam logic [8:0] PAGE_LAST = 9'h1ff;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // Sense-amplifier timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int ONE_SHOT_NS = 50;
    localparam int ONE_SHOT_CYC = (ONE_SHOT_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam logic [2:0] ONE_SHOT_LAST = 3'(ONE_SHOT_CYC - 1);
    localparam logic [2:0] FULL_CYCLE_LAST = 3'h0;

    // Driver registers on AXI4-Lite (byte addresses).
    localparam int AXI_AW = 8;
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_RESULT = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_INT_EN = 8'h10;
    localparam logic [7:0] REG_INT_CLR = 8'h14;
    localparam int RESULT_BUSY_BIT = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Command opcodes in bits 17:16 of the command register.
    localparam logic [1:0] OP_FLASH_READ = 2'h0;
    localparam logic [1:0] OP_SFR_WRITE = 2'h1;
    localparam logic [1:0] OP_SFR_READ = 2'h2;
    localparam logic [1:0] OP_MOVE_WRITE = 2'h3;

    // Status bits: command finished, command refused while busy.
    localparam int EV_DONE = 0;
    localparam int EV_REFUSED = 1;
    localparam int EV_N = 2;

    typedef enum logic [1:0] {
        FPEG_D_IDLE,
        FPEG_D_ERASE,
        FPEG_D_SENSE
    } fpeg_dstate_t;

    typedef enum logic [2:0] {
        FPEG_H_IDLE,
        FPEG_H_SFR_RD,
        FPEG_H_SFR_RD2,
        FPEG_H_MOVE,
        FPEG_H_FREAD
    } fpeg_hstate_t;

endpackage : fpeg_pkg

`default_nettype wire

// ---- pkg/fpeg_link_if.sv ----
// Link between the flash gate and the core-side driver.
`default_nettype none

interface fpeg_link_if;
    import fpeg_pkg::*;

    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic mv_valid;
    logic mv_ready;
    logic [FLASH_AW-1:0] mv_addr;
    logic [7:0] mv_data;
    logic fr_valid;
    logic fr_ready;
    logic [FLASH_AW-1:0] fr_addr;
    logic [7:0] fr_data;
    logic fr_done;
    logic sense_on;

    modport gate (
        input sfr_wr, sfr_rd, sfr_addr, sfr_wdata,
        output sfr_rdata,
        input mv_valid, mv_addr, mv_data,
        output mv_ready,
        input fr_valid, fr_addr,
        output fr_ready, fr_data, fr_done, sense_on
    );

    modport core (
        output sfr_wr, sfr_rd, sfr_addr, sfr_wdata,
        input sfr_rdata,
        output mv_valid, mv_addr, mv_data,
        input mv_ready,
        output fr_valid, fr_addr,
        input fr_ready, fr_data, fr_done, sense_on
    );

endinterface : fpeg_link_if

`default_nettype wire

// ---- hw/fpeg_gate.sv ----
// Flash program/erase gate: control registers, unlock key and flash array.
//
// Summary of operation
// - Control bits 7..2 read zero, writes ignored.
// - Erase plus write enable erases whole page.
// - Write enable steers moves to program bytes.
// - Write enable clear keeps moves off flash.
// - Software erases a location before programming.
// - Unlock needs first then second key code.
// - Each unlock allows exactly one operation.
// - Wrong key or early operation locks out.
// - Key read shows lock state in bits 1..0.
// - One-shot selects 50 ns sense pulse.
// - Timing bits 6..0 read zero, write zero.
// - Program only clears bits; erase sets ones.
// - Pages are 512 bytes; erase covers page.
// - Write enable stays set until software clears.
`default_nettype none

module fpeg_gate (
    input wire logic aclk,
    input wire logic aresetn,
    fpeg_link_if.gate link
);
    import fpeg_pkg::*;

    typedef struct packed {
        logic write_en;
        logic erase_en;
        logic one_shot;
        logic [1:0] lock;
        fpeg_dstate_t st;
        logic [PAGE_AW-1:0] cnt;
        logic [FLASH_AW-PAGE_AW-1:0] page;
        logic [FLASH_AW-1:0] raddr;
        logic [2:0] scnt;
        logic sense_on;
        logic [7:0] sfr_rdata;
        logic [7:0] fr_data;
        logic fr_done;
    } fpeg_gate_state_t;

    fpeg_gate_state_t s;
    fpeg_gate_state_t next_s;

    // The array is kept outside the state record; it is too large to reset
    // and software is expected to erase a page before using it.
    logic [7:0] mem [FLASH_BYTES];
    logic mem_we;
    logic [FLASH_AW-1:0] mem_wa;
    logic [7:0] mem_wd;

    assign link.mv_ready = (s.st == FPEG_D_IDLE);
    // A move offered in the same cycle as a read goes first; the read waits.
    assign link.fr_ready = (s.st == FPEG_D_IDLE) && !link.mv_valid;
    assign link.sfr_rdata = s.sfr_rdata;
    assign link.fr_data = s.fr_data;
    assign link.fr_done = s.fr_done;
    assign link.sense_on = s.sense_on;

    always_comb begin
        next_s = s;
        next_s.fr_done = 1'b0;
        mem_we = 1'b0;
        mem_wa = link.mv_addr;
        mem_wd = 8'h00;

        // Register reads return on the following cycle.
        if (link.sfr_rd) begin
            unique case (link.sfr_addr)
                SFR_STORE_CTRL: begin
                    next_s.sfr_rdata = {6'h00, s.erase_en, s.write_en};
                end

                SFR_UNLOCK_KEY: begin
                    next_s.sfr_rdata = {6'h00, s.lock};
                end

                SFR_READ_TIMING: begin
                    next_s.sfr_rdata = {s.one_shot, 7'h00};
                end

                default: begin
                    next_s.sfr_rdata = 8'h00;
                end
            endcase
        end

        if (link.sfr_wr) begin
            unique case (link.sfr_addr)
                SFR_STORE_CTRL: begin
                    // Upper bits are dropped; the enables hold until the
                    // next write here, whatever the flash does meanwhile.
                    next_s.write_en = link.sfr_wdata[WRITE_EN_BIT];
                    next_s.erase_en = link.sfr_wdata[ERASE_EN_BIT];
                end

                SFR_READ_TIMING: begin
                    next_s.one_shot = link.sfr_wdata[ONE_SHOT_BIT];
                end

                SFR_UNLOCK_KEY: begin
                    unique case (s.lock)
                        LOCK_LOCKED: begin
                            next_s.lock = (link.sfr_wdata == KEY_FIRST) ?
                                LOCK_FIRST : LOCK_DEAD;
                        end

                        LOCK_FIRST: begin
                            next_s.lock = (link.sfr_wdata == KEY_SECOND) ?
                                LOCK_OPEN : LOCK_DEAD;
                        end

                        LOCK_OPEN: begin
                            // A third key write is a wrong code.
                            next_s.lock = LOCK_DEAD;
                        end

                        LOCK_DEAD: begin
                            next_s.lock = LOCK_DEAD;
                        end
                    endcase
                end
                default: begin
                end
            endcase
        end

        unique case (s.st)
            FPEG_D_IDLE: begin
                if (link.mv_valid) begin
                    // With write enable clear the move targets data memory,
                    // which is not modelled here, so flash is untouched.
                    if (s.write_en) begin
                        if (s.lock == LOCK_OPEN) begin
                            next_s.lock = LOCK_LOCKED;
                            if (s.erase_en) begin
                                next_s.st = FPEG_D_ERASE;
                                next_s.page = link.mv_addr[FLASH_AW-1:PAGE_AW];
                                next_s.cnt = '0;
                            end else begin
                                mem_we = 1'b1;
                                mem_wd = mem[link.mv_addr] & link.mv_data;
                            end
                        end else begin
                            next_s.lock = LOCK_DEAD;
                        end
                    end
                end else if (link.fr_valid) begin
                    next_s.st = FPEG_D_SENSE;
                    next_s.raddr = link.fr_addr;
                    next_s.sense_on = 1'b1;
                    next_s.scnt = s.one_shot ? ONE_SHOT_LAST
                        : FULL_CYCLE_LAST;
                end
            end

            FPEG_D_ERASE: begin
                // One byte per clock; the data byte of the move is unused.
                mem_we = 1'b1;
                mem_wa = {s.page, s.cnt};
                mem_wd = ERASED_BYTE;
                next_s.cnt = s.cnt + 9'h001;
                if (s.cnt == PAGE_LAST) begin
                    next_s.st = FPEG_D_IDLE;
                end
            end

            FPEG_D_SENSE: begin
                if (s.scnt == 3'h0) begin
                    next_s.sense_on = 1'b0;
                    next_s.fr_data = mem[s.raddr];
                    next_s.fr_done = 1'b1;
                    next_s.st = FPEG_D_IDLE;
                end else begin
                    next_s.scnt = s.scnt - 3'h1;
                end
            end

            default: begin
                next_s.st = FPEG_D_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.write_en <= STORE_CTRL_RESET[WRITE_EN_BIT];
            s.erase_en <= STORE_CTRL_RESET[ERASE_EN_BIT];
            s.one_shot <= READ_TIMING_RESET[ONE_SHOT_BIT];
            s.lock <= LOCK_LOCKED;
            s.st <= FPEG_D_IDLE;
        end else begin
            s <= next_s;
        end
    end

    always_ff @(posedge aclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

endmodule // fpeg_gate

`default_nettype wire

// ---- tb/fpeg_link_assertions.sv ----
// Checker of the link between the flash gate and its core-side driver.
`default_nettype none

module fpeg_link_assertions
    import fpeg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic mv_valid,
    input wire logic mv_ready,
    input wire logic fr_done,
    input wire logic sense_on
);
    // Shadow copies of the gate state, rebuilt from link traffic only.
    logic os, we, ee, era;
    logic [1:0] lk;
    logic [9:0] cnt;
    wire take = mv_valid && mv_ready;
    wire era_take = take && we && ee && lk == LOCK_OPEN;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            os <= 1'b1;
            {ee, we} <= 2'h0;
            lk <= LOCK_LOCKED;
            era <= 1'b0;
            cnt <= 10'h0;
        end else begin
            if (sfr_wr && sfr_addr == SFR_STORE_CTRL)
                {ee, we} <= sfr_wdata[1:0];
            if (sfr_wr && sfr_addr == SFR_READ_TIMING)
                os <= sfr_wdata[7];
            if (sfr_wr && sfr_addr == SFR_UNLOCK_KEY)
                lk <= (lk == LOCK_LOCKED && sfr_wdata == KEY_FIRST) ?
                    LOCK_FIRST : (lk == LOCK_FIRST &&
                    sfr_wdata == KEY_SECOND) ? LOCK_OPEN : LOCK_DEAD;
            else if (take && we)
                lk <= (lk == LOCK_OPEN) ? LOCK_LOCKED : LOCK_DEAD;
            era <= era_take ? 1'b1 : (mv_ready ? 1'b0 : era);
            cnt <= mv_ready ? 10'h0 : cnt + 10'h1;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_ctrl_read;
        sfr_rd && sfr_addr == SFR_STORE_CTRL |=> sfr_rdata == {6'h0, ee, we};
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("control readback wrong");
    property p_timing_read;
        sfr_rd && sfr_addr == SFR_READ_TIMING |=> sfr_rdata == {os, 7'h0};
    endproperty
    a_timing_read: assert property (p_timing_read)
        else $error("timing readback wrong");
    property p_lock_read;
        sfr_rd && sfr_addr == SFR_UNLOCK_KEY |=> sfr_rdata == {6'h0, lk};
    endproperty
    a_lock_read: assert property (p_lock_read)
        else $error("lock state wrong");
    property p_os_pulse;
        $rose(sense_on) && os |-> sense_on [*5] ##1 !sense_on;
    endproperty
    a_os_pulse: assert property (p_os_pulse)
        else $error("one-shot sense pulse length wrong");
    property p_full_cycle;
        $rose(sense_on) && !os |=> !sense_on;
    endproperty
    a_full_cycle: assert property (p_full_cycle)
        else $error("full-cycle sense length wrong");
    property p_read_done;
        $fell(sense_on) |-> fr_done;
    endproperty
    a_read_done: assert property (p_read_done)
        else $error("read done not after sense");
    property p_erase_stall;
        era_take |=> !mv_ready [*8];
    endproperty
    a_erase_stall: assert property (p_erase_stall)
        else $error("erase did not start");
    property p_erase_len;
        $rose(mv_ready) && era |-> cnt >= 10'h1ff && cnt <= 10'h201;
    endproperty
    a_erase_len: assert property (p_erase_len)
        else $error("erase length wrong");
    property p_prog_quick;
        take && !era_take |=> mv_ready;
    endproperty
    a_prog_quick: assert property (p_prog_quick)
        else $error("byte move stalled");
endmodule // fpeg_link_assertions

`default_nettype wire

// ---- tb/flash_program_erase_gate_test.sv ----
// Self-checking bench for the flash gate and its AXI4-Lite driver.
`default_nettype none

module flash_program_erase_gate_test
    import fpeg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, irq;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] v;
    int num_errors = 0, check_count = 0, cycles = 0;

    fpeg_link_if link ();
    fpeg_gate i_fpeg_gate (.aclk, .aresetn, .link(link));
    fpeg_core i_fpeg_core (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .link(link));
    fpeg_link_assertions i_chk (.aclk, .aresetn, .sfr_wr(link.sfr_wr),
        .sfr_rd(link.sfr_rd), .sfr_addr(link.sfr_addr),
        .sfr_wdata(link.sfr_wdata), .sfr_rdata(link.sfr_rdata),
        .mv_valid(link.mv_valid), .mv_ready(link.mv_ready),
        .fr_done(link.fr_done), .sense_on(link.sense_on));

    always #5 aclk = ~aclk;

    task automatic print_verdict();
        if (num_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // The whole run needs about a thousand cycles; this is a generous cap.
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors = num_errors + 1;
            print_verdict();
        end
    end

    task automatic check(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] rs);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic cmd(input logic [1:0] op, input logic [7:0] a, d);
        logic [1:0] rs;
        logic [31:0] x;
        wr(REG_CMD, {14'h0, op, a, d}, rs);
        for (int i = 0; i < 400; i++) begin
            rd(REG_RESULT, x, rs);
            if (x[RESULT_BUSY_BIT] === 1'b0)
                break;
        end
        check("busy", {31'h0, x[RESULT_BUSY_BIT]}, 32'h0);
    endtask

    task automatic sw(input logic [7:0] a, d);
        cmd(OP_SFR_WRITE, a, d);
    endtask

    task automatic chk_sfr(input logic [7:0] a, e);
        cmd(OP_SFR_READ, a, 8'h0);
        rd(REG_RESULT, v, r);
        check("register", {24'h0, v[7:0]}, {24'h0, e});
    endtask

    task automatic move(input logic [12:0] fa, input logic [7:0] d);
        wr(REG_ADDR, {19'h0, fa}, r);
        cmd(OP_MOVE_WRITE, 8'h0, d);
    endtask

    task automatic fchk(input logic [12:0] fa, input logic [7:0] e);
        wr(REG_ADDR, {19'h0, fa}, r);
        cmd(OP_FLASH_READ, 8'h0, 8'h0);
        rd(REG_RESULT, v, r);
        check("flash byte", {24'h0, v[7:0]}, {24'h0, e});
    endtask

    task automatic unlock();
        sw(SFR_UNLOCK_KEY, KEY_FIRST);
        sw(SFR_UNLOCK_KEY, KEY_SECOND);
    endtask

    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    task automatic t_regs();
        chk_sfr(SFR_STORE_CTRL, STORE_CTRL_RESET);
        chk_sfr(SFR_READ_TIMING, READ_TIMING_RESET);
        chk_sfr(SFR_UNLOCK_KEY, 8'h00);
        sw(SFR_STORE_CTRL, 8'hff);
        chk_sfr(SFR_STORE_CTRL, 8'h03);
        sw(SFR_READ_TIMING, 8'h00);
        chk_sfr(SFR_READ_TIMING, 8'h00);
        sw(SFR_READ_TIMING, 8'h80);
        rd(8'h20, v, r);
        check("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
        wr(REG_RESULT, 32'h0, r);
        check("result write resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    endtask

    task automatic t_erase_prog();
        unlock();
        chk_sfr(SFR_UNLOCK_KEY, 8'h02);
        move(13'h02a7, 8'h00);
        chk_sfr(SFR_UNLOCK_KEY, 8'h00);
        chk_sfr(SFR_STORE_CTRL, 8'h03);
        fchk(13'h0200, ERASED_BYTE);
        fchk(13'h03ff, ERASED_BYTE);
        sw(SFR_STORE_CTRL, 8'h01);
        unlock();
        move(13'h0210, 8'h5a);
        fchk(13'h0210, 8'h5a);
        unlock();
        move(13'h0210, 8'hf0);
        fchk(13'h0210, 8'h50);
        move(13'h0210, 8'h00);
        chk_sfr(SFR_UNLOCK_KEY, 8'h03);
        fchk(13'h0210, 8'h50);
        sw(SFR_UNLOCK_KEY, KEY_FIRST);
        chk_sfr(SFR_UNLOCK_KEY, 8'h03);
    endtask

    task automatic t_keys();
        do_reset();
        sw(SFR_UNLOCK_KEY, KEY_FIRST);
        chk_sfr(SFR_UNLOCK_KEY, 8'h01);
        repeat (40) @(posedge aclk);
        sw(SFR_UNLOCK_KEY, KEY_SECOND);
        chk_sfr(SFR_UNLOCK_KEY, 8'h02);
        move(13'h0210, 8'h00);
        fchk(13'h0210, 8'h50);
        chk_sfr(SFR_UNLOCK_KEY, 8'h02);
        sw(SFR_UNLOCK_KEY, 8'h12);
        chk_sfr(SFR_UNLOCK_KEY, 8'h03);
        do_reset();
        sw(SFR_UNLOCK_KEY, KEY_SECOND);
        chk_sfr(SFR_UNLOCK_KEY, 8'h03);
    endtask

    task automatic t_sense_irq();
        sw(SFR_READ_TIMING, 8'h00);
        fchk(13'h0210, 8'h50);
        sw(SFR_READ_TIMING, 8'h80);
        fchk(13'h0210, 8'h50);
        wr(REG_INT_CLR, 32'h3, r);
        wr(REG_INT_EN, 32'h1, r);
        sw(SFR_STORE_CTRL, 8'h00);
        check("irq raised", {31'h0, irq}, 32'h1);
        wr(REG_INT_CLR, 32'h1, r);
        check("irq cleared", {31'h0, irq}, 32'h0);
        wr(REG_INT_EN, 32'h0, r);
        sw(SFR_STORE_CTRL, 8'h00);
        check("irq masked", {31'h0, irq}, 32'h0);
        rd(REG_STATUS, v, r);
        check("status done", {31'h0, v[EV_DONE]}, 32'h1);
        wr(REG_CMD, {14'h0, OP_FLASH_READ, 16'h0}, r);
        wr(REG_CMD, 32'h0, r);
        rd(REG_STATUS, v, r);
        check("refused", {31'h0, v[EV_REFUSED]}, 32'h1);
    endtask

    initial begin
        do_reset();
        t_regs();
        t_erase_prog();
        t_keys();
        t_sense_irq();
        print_verdict();
    end
endmodule // flash_program_erase_gate_test

`default_nettype wire
